// ---- core/mted_pkg.sv ----
package mted_pkg;
	// Register bus and sample widths, event count
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int SAMPLE_W = 16;
	localparam int EVT_N = 6;
	// Register offsets
	localparam logic [7:0] ADDR_CTRL2 = 8'h21;
	localparam logic [7:0] ADDR_CTRL3 = 8'h22;
	localparam logic [7:0] ADDR_Y_LO = 8'h2A;
	localparam logic [7:0] ADDR_Y_HI = 8'h2B;
	localparam logic [7:0] ADDR_Z_LO = 8'h2C;
	localparam logic [7:0] ADDR_Z_HI = 8'h2D;
	localparam logic [7:0] ADDR_EVT_CFG = 8'h30;
	localparam logic [7:0] ADDR_EVT_SRC = 8'h31;
	localparam logic [7:0] ADDR_EVT_ACK = 8'h32;
	localparam logic [7:0] ADDR_THR_LO = 8'h34;
	localparam logic [7:0] ADDR_THR_HI = 8'h35;
	localparam logic [7:0] ADDR_DUR = 8'h36;
	// Field positions
	localparam int CTRL2_BYTE_ORDER_BIT = 5;
	localparam int CTRL2_ALIGN_BIT = 0;
	localparam int CTRL3_HP_BIT = 5;
	localparam int CFG_COMBINE_BIT = 7;
	localparam int CFG_LATCH_BIT = 6;
	localparam int SRC_ACTIVE_BIT = 6;
	// Right-justify shift for the 12-bit form
	localparam int ALIGN12_SHIFT = 4;
	// Default high-pass smoothing shift, in bits
	localparam int HP_SHIFT_DEF = 4;
	// Values after reset
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [15:0] THR_RST = 16'h0000;
	localparam logic [7:0] DUR_RST = 8'h00;
	localparam logic [15:0] SAMPLE_RST = 16'h0000;
	localparam logic [5:0] FLAGS_RST = 6'h00;
	localparam logic [8:0] RUN_RST = 9'h000;
endpackage

// ---- core/mted_axis_if.sv ----
`timescale 1ns/100ps
// One axis: sample and setup to the comparator, high and low back
interface mted_axis_if;
	logic [mted_pkg::SAMPLE_W-1:0] smp; // Raw left-justified sample
	logic smp_vld; // New sample strobe
	logic hp_en; // Use the high-passed value
	logic [mted_pkg::SAMPLE_W-1:0] thr; // Unsigned magnitude threshold
	logic hi; // Magnitude above threshold
	logic lo; // Magnitude below threshold
	modport cmp (input smp, smp_vld, hp_en, thr, output hi, lo);
	modport ctl (output smp, smp_vld, hp_en, thr, input hi, lo);
endinterface

// ---- core/mted_axis_cmp.sv ----
`timescale 1ns/100ps
module mted_axis_cmp #(
	parameter int HP_SHIFT = mted_pkg::HP_SHIFT_DEF // Filter smoothing shift
) (
	input wire logic clk, // System clock
	input wire logic rstn, // Async reset, active low
	mted_axis_if.cmp ax // Axis sample and verdict
);
	import mted_pkg::*;

	logic signed [SAMPLE_W-1:0] base_ff; // Running baseline for the filter
	logic signed [SAMPLE_W:0] diff; // Sample minus baseline
	logic signed [SAMPLE_W:0] val; // Value that meets the threshold
	logic signed [SAMPLE_W:0] mag; // Its magnitude
	logic signed [SAMPLE_W:0] step; // Baseline step per sample
	logic [SAMPLE_W:0] thr_ext; // Threshold widened

	// High-pass as sample minus a slow baseline; cheap, no multiplier
	always_comb begin
		diff = {ax.smp[SAMPLE_W-1], ax.smp} - {base_ff[SAMPLE_W-1], base_ff};
		step = diff >>> HP_SHIFT;
		val = ax.hp_en ? diff : {ax.smp[SAMPLE_W-1], ax.smp};
		mag = val[SAMPLE_W] ? -val : val;
		thr_ext = {1'b0, ax.thr};
	end

	// Baseline tracks every sample so that enabling the filter starts settled
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			base_ff <= SAMPLE_RST;
		end else if (ax.smp_vld) begin
			base_ff <= base_ff + step[SAMPLE_W-1:0];
		end
	end

	// Magnitude compare; equal to threshold is neither high nor low
	assign ax.hi = $unsigned(mag) > thr_ext;
	assign ax.lo = $unsigned(mag) < thr_ext;

	thr_split_a: assert property (@(posedge clk) disable iff (!rstn)
		(!ax.hp_en && ax.hi) |-> !ax.lo && (ax.smp != ax.thr))
		else $error("high and low verdicts disagree");
endmodule

// ---- core/mted_top.sv ----
`timescale 1ns/100ps
module mted_top (
	input wire logic clk, // System clock, 100 MHz
	input wire logic rstn, // Async reset, active low
	input wire logic [mted_pkg::SAMPLE_W-1:0] smp_x, // X sample, left-justified
	input wire logic [mted_pkg::SAMPLE_W-1:0] smp_y, // Y sample, left-justified
	input wire logic [mted_pkg::SAMPLE_W-1:0] smp_z, // Z sample, left-justified
	input wire logic smp_vld, // One-cycle strobe per output sample period
	input wire logic [mted_pkg::ADDR_W-1:0] reg_addr, // Register address
	input wire logic [mted_pkg::DATA_W-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [mted_pkg::DATA_W-1:0] reg_rdata, // Read data, next cycle
	output logic irq // Event interrupt request
);
	import mted_pkg::*;

	// Stored control state
	logic [DATA_W-1:0] ctrl2_ff; // Byte order and alignment
	logic [DATA_W-1:0] ctrl3_ff; // High-pass enable
	logic [DATA_W-1:0] cfg_ff; // Combine, latch, six enables
	logic [SAMPLE_W-1:0] thr_ff; // Event threshold
	logic [DATA_W-1:0] dur_ff; // Minimum duration in samples
	// Output and event state
	logic [SAMPLE_W-1:0] y_ff; // Held Y sample
	logic [SAMPLE_W-1:0] z_ff; // Held Z sample
	logic [EVT_N-1:0] flags_ff; // Six event flags
	logic active_ff; // Interrupt active flag
	logic [8:0] run_ff; // Consecutive qualifying samples, saturating
	logic [DATA_W-1:0] reg_rdata_ff; // Registered read data

	// Decoded control bits
	logic byte_order_select; // 1 selects big-endian
	logic alignment_select; // 1 selects 16-bit left-justified
	logic motion_highpass_enable; // 1 routes filtered samples
	logic event_combine_select; // 1 selects AND
	logic latch_request_enable; // 1 latches flags
	logic [EVT_N-1:0] evt_en; // {z_high_enable .. x_low_enable}

	// Event evaluation
	logic [2:0] ax_hi; // Per-axis high verdict
	logic [2:0] ax_lo; // Per-axis low verdict
	logic [EVT_N-1:0] evt_raw; // {zh, zl, yh, yl, xh, xl}
	logic [EVT_N-1:0] evt_hit; // Enabled events present
	logic cond; // Combined condition on this sample
	logic [8:0] run_now; // Run length including this sample
	logic qual; // Condition held long enough
	logic [EVT_N-1:0] new_flags; // Flags this sample contributes
	logic ack_rd; // Acknowledge read this cycle
	logic [8:0] nxt_run; // Next run length
	logic [SAMPLE_W-1:0] fmt_y; // Y in the selected alignment
	logic [SAMPLE_W-1:0] fmt_z; // Z in the selected alignment
	logic [DATA_W-1:0] nxt_rdata; // Read data before the flop

	assign byte_order_select = ctrl2_ff[CTRL2_BYTE_ORDER_BIT];
	assign alignment_select = ctrl2_ff[CTRL2_ALIGN_BIT];
	assign motion_highpass_enable = ctrl3_ff[CTRL3_HP_BIT];
	assign event_combine_select = cfg_ff[CFG_COMBINE_BIT];
	assign latch_request_enable = cfg_ff[CFG_LATCH_BIT];
	assign evt_en = cfg_ff[EVT_N-1:0];
	assign ack_rd = reg_rd && (reg_addr == ADDR_EVT_ACK);

	// One comparator per axis, all sharing threshold and filter select
	logic [SAMPLE_W-1:0] smp_vec [3];
	assign smp_vec[0] = smp_x;
	assign smp_vec[1] = smp_y;
	assign smp_vec[2] = smp_z;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_axis
			mted_axis_if ax ();
			assign ax.smp = smp_vec[gi];
			assign ax.smp_vld = smp_vld;
			assign ax.hp_en = motion_highpass_enable;
			assign ax.thr = thr_ff;
			assign ax_hi[gi] = ax.hi;
			assign ax_lo[gi] = ax.lo;
			assign evt_raw[2*gi+1] = ax.hi;
			assign evt_raw[2*gi] = ax.lo;
			mted_axis_cmp #(
				.HP_SHIFT(HP_SHIFT_DEF)
			) u_cmp (
				.clk(clk),
				.rstn(rstn),
				.ax(ax.cmp)
			);
		end
	endgenerate

	// Combine the enabled events; AND with nothing enabled never fires
	always_comb begin
		evt_hit = evt_raw & evt_en;
		if (event_combine_select) begin
			cond = (|evt_en) && (&(evt_raw | ~evt_en));
		end else begin
			cond = |evt_hit;
		end
		run_now = (run_ff == 9'h1FF) ? run_ff : run_ff + 9'h001;
		// Duration zero means the first qualifying sample counts
		qual = cond && (run_now >= {1'b0, dur_ff});
		new_flags = qual ? evt_hit : FLAGS_RST;
		nxt_run = cond ? run_now : RUN_RST;
	end

	// Run length counts samples, not clocks, so duration is in rate periods
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_ff <= RUN_RST;
		end else if (smp_vld) begin
			run_ff <= nxt_run;
		end
	end

	// Source flags and active flag; a sample in the acknowledge cycle wins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags_ff <= FLAGS_RST;
			active_ff <= 1'b0;
		end else if (smp_vld) begin
			if (latch_request_enable && !ack_rd) begin
				// Latched: only ever add, until acknowledged
				flags_ff <= flags_ff | new_flags;
				active_ff <= active_ff | qual;
			end else begin
				// Unlatched, or refresh on acknowledge: take the fresh state
				flags_ff <= new_flags;
				active_ff <= qual;
			end
		end else if (ack_rd && latch_request_enable) begin
			// Acknowledge read with no sample: release the latch
			flags_ff <= FLAGS_RST;
			active_ff <= 1'b0;
		end
	end

	// Hold the Y and Z samples for register reads
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			y_ff <= SAMPLE_RST;
			z_ff <= SAMPLE_RST;
		end else if (smp_vld) begin
			y_ff <= smp_y;
			z_ff <= smp_z;
		end
	end

	// Writable registers; read-only and unmapped writes are dropped
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl2_ff <= CTRL_RST;
			ctrl3_ff <= CTRL_RST;
			cfg_ff <= CFG_RST;
			thr_ff <= THR_RST;
			dur_ff <= DUR_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_CTRL2: begin
					ctrl2_ff <= reg_wdata;
				end
				ADDR_CTRL3: begin
					ctrl3_ff <= reg_wdata;
				end
				ADDR_EVT_CFG: begin
					cfg_ff <= reg_wdata;
				end
				ADDR_THR_LO: begin
					thr_ff[7:0] <= reg_wdata;
				end
				ADDR_THR_HI: begin
					thr_ff[15:8] <= reg_wdata;
				end
				ADDR_DUR: begin
					dur_ff <= reg_wdata;
				end
				default: begin
					// Nothing to store
				end
			endcase
		end
	end

	// 12-bit form is the top twelve bits shifted down and sign-extended
	always_comb begin
		if (alignment_select) begin
			fmt_y = y_ff;
			fmt_z = z_ff;
		end else begin
			fmt_y = $unsigned($signed(y_ff) >>> ALIGN12_SHIFT);
			fmt_z = $unsigned($signed(z_ff) >>> ALIGN12_SHIFT);
		end
	end

	// Read mux; the acknowledge register reads as zero, not meaningful
	always_comb begin
		case (reg_addr)
			ADDR_CTRL2: begin
				nxt_rdata = ctrl2_ff;
			end
			ADDR_CTRL3: begin
				nxt_rdata = ctrl3_ff;
			end
			ADDR_Y_LO: begin
				nxt_rdata = byte_order_select ? fmt_y[15:8] : fmt_y[7:0];
			end
			ADDR_Y_HI: begin
				nxt_rdata = byte_order_select ? fmt_y[7:0] : fmt_y[15:8];
			end
			ADDR_Z_LO: begin
				nxt_rdata = byte_order_select ? fmt_z[15:8] : fmt_z[7:0];
			end
			ADDR_Z_HI: begin
				nxt_rdata = byte_order_select ? fmt_z[7:0] : fmt_z[15:8];
			end
			ADDR_EVT_CFG: begin
				nxt_rdata = cfg_ff;
			end
			ADDR_EVT_SRC: begin
				nxt_rdata = {1'b0, active_ff, flags_ff};
			end
			ADDR_THR_LO: begin
				nxt_rdata = thr_ff[7:0];
			end
			ADDR_THR_HI: begin
				nxt_rdata = thr_ff[15:8];
			end
			ADDR_DUR: begin
				nxt_rdata = dur_ff;
			end
			default: begin
				nxt_rdata = 8'h00;
			end
		endcase
	end

	// Read data is captured only on a read so it stays stable between reads
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = reg_rdata_ff;
	assign irq = active_ff;

	// Steps of the latched handshake, and a register read
	sequence s_latched_hold;
		latch_request_enable && active_ff && !ack_rd && !smp_vld;
	endsequence

	sequence s_ack_release;
		latch_request_enable && ack_rd && !smp_vld;
	endsequence

	sequence s_rd(logic [7:0] a);
		reg_rd && (reg_addr == a);
	endsequence

	y_lo_little_a: assert property (@(posedge clk) disable iff (!rstn)
		s_rd(ADDR_Y_LO) ##0 (!byte_order_select && alignment_select)
		|=> reg_rdata == $past(y_ff[7:0]))
		else $error("Y low byte wrong in little-endian");

	y_hi_little_a: assert property (@(posedge clk) disable iff (!rstn)
		s_rd(ADDR_Y_HI) ##0 (!byte_order_select && alignment_select)
		|=> reg_rdata == $past(y_ff[15:8]))
		else $error("Y high byte wrong in little-endian");

	z_hi_little_a: assert property (@(posedge clk) disable iff (!rstn)
		s_rd(ADDR_Z_HI) ##0 (!byte_order_select && alignment_select)
		|=> reg_rdata == $past(z_ff[15:8]))
		else $error("Z high byte wrong in little-endian");

	big_lo_addr_a: assert property (@(posedge clk) disable iff (!rstn)
		s_rd(ADDR_Z_LO) ##0 (byte_order_select && alignment_select)
		|=> reg_rdata == $past(z_ff[15:8]))
		else $error("Big-endian low address lacks high byte");

	big_hi_addr_a: assert property (@(posedge clk) disable iff (!rstn)
		s_rd(ADDR_Y_HI) ##0 (byte_order_select && alignment_select)
		|=> reg_rdata == $past(y_ff[7:0]))
		else $error("Big-endian high address lacks low byte");

	sign_extend_a: assert property (@(posedge clk) disable iff (!rstn)
		s_rd(ADDR_Y_HI) ##0 (!byte_order_select && !alignment_select)
		|=> reg_rdata[7:4] == {4{$past(y_ff[15])}})
		else $error("12-bit form not sign-extended");

	and_combine_a: assert property (@(posedge clk) disable iff (!rstn)
		(smp_vld && event_combine_select && !latch_request_enable
		&& (evt_hit != evt_en)) |=> !active_ff)
		else $error("AND combine fired with an event missing");

	or_combine_a: assert property (@(posedge clk) disable iff (!rstn)
		(smp_vld && !event_combine_select && (dur_ff == 8'h00) && (|evt_hit))
		|=> active_ff && ((flags_ff & evt_en) != 6'h00))
		else $error("OR combine missed an enabled event");

	latch_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		s_latched_hold |=> active_ff && (flags_ff == $past(flags_ff)))
		else $error("Latched request dropped without acknowledge");

	ack_release_a: assert property (@(posedge clk) disable iff (!rstn)
		s_ack_release |=> !active_ff && (flags_ff == 6'h00) ##1 ($past(smp_vld) || !irq))
		else $error("Acknowledge read did not release latch");

	unlatched_follow_a: assert property (@(posedge clk) disable iff (!rstn)
		(smp_vld && !latch_request_enable && !cond) |=> !active_ff
		&& (flags_ff == 6'h00))
		else $error("Unlatched flags kept an old event");

	min_duration_a: assert property (@(posedge clk) disable iff (!rstn)
		(smp_vld && !latch_request_enable && (run_ff == 9'h000)
		&& (dur_ff >= 8'h02)) |=> !active_ff)
		else $error("Event recognised before its duration");

	irq_follow_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(irq) |-> $past(smp_vld) && active_ff)
		else $error("Interrupt rose without a sample");
endmodule

// ---- bench/mted_host_model.sv ----
`timescale 1ns/100ps
// Host side of the register port: one-cycle strobes launched just after an edge
module mted_host_model (
	input wire logic clk, // System clock
	output logic [mted_pkg::ADDR_W-1:0] reg_addr, // Register address
	output logic [mted_pkg::DATA_W-1:0] reg_wdata, // Write data
	output logic reg_wr, // Write strobe
	output logic reg_rd, // Read strobe
	input wire logic [mted_pkg::DATA_W-1:0] reg_rdata // Read data
);
	import mted_pkg::*;
	// Idle bus from time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Single write; the strobe covers exactly one rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk) #1;
		reg_wr = 1'b0;
	endtask
	// Single read; data is settled just after the edge that samples the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) #1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk) #1;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
	// Acknowledge read; the returned byte carries no meaning, so it is dropped
	task automatic ack();
		logic [7:0] junk;
		rd(ADDR_EVT_ACK, junk);
	endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/100ps
module tb;
	import mted_pkg::*;
	logic clk = 1'b0; // 100 MHz system clock
	logic rstn = 1'b0; // Reset, active low
	logic [15:0] smp_x = 16'h0000; // X sample
	logic [15:0] smp_y = 16'h0000; // Y sample
	logic [15:0] smp_z = 16'h0000; // Z sample
	logic smp_vld = 1'b0; // Sample strobe
	logic [7:0] reg_addr; // Driven by host model
	logic [7:0] reg_wdata; // Driven by host model
	logic reg_wr; // Driven by host model
	logic reg_rd; // Driven by host model
	logic [7:0] reg_rdata; // Read data from the block
	logic irq; // Event request
	logic [15:0] v16; // Scratch sample value
	int errors = 0; // Mismatches
	int checks_done = 0; // Comparisons made
	int cycles = 0; // Run length guard
	// Registers that must read zero after reset
	logic [7:0] rst_list [7] = '{ADDR_CTRL2, ADDR_CTRL3, ADDR_EVT_CFG, ADDR_EVT_SRC,
		ADDR_THR_LO, ADDR_THR_HI, ADDR_DUR};
	// Format modes and expected Y lo, Y hi, Z lo, Z hi bytes
	logic [7:0] fmt_mode [4] = '{8'h00, 8'h01, 8'h20, 8'h21};
	logic [31:0] fmt_exp [4] = '{32'hA5F82301, 32'h508A3412, 32'hF8A50123, 32'h8A501234};

	always #5 clk = ~clk;

	mted_top u_dut (
		.clk(clk),
		.rstn(rstn),
		.smp_x(smp_x),
		.smp_y(smp_y),
		.smp_z(smp_z),
		.smp_vld(smp_vld),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.irq(irq)
	);
	mted_host_model u_host (
		.clk(clk),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata)
	);

	// Byte compare
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request line compare, widened to a byte; the case inequality in chk keeps an unknown from matching
	task automatic ichk(input logic exp);
		chk({7'h00, irq}, {7'h00, exp});
	endtask
	// Read a register and compare
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_host.rd(a, d);
		chk(d, exp);
	endtask
	// One sample period on all three axes
	task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
		@(posedge clk) #1;
		smp_x = x;
		smp_y = y;
		smp_z = z;
		smp_vld = 1'b1;
		@(posedge clk) #1;
		smp_vld = 1'b0;
	endtask
	// Counts, verdict, end of run
	task automatic print_verdict();
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Guard against a hang; the sequence needs well under 2000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			print_verdict();
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		#1 rstn = 1'b1;
		// Reset values, then read-only and unmapped places
		foreach (rst_list[i]) rchk(rst_list[i], 8'h00);
		ichk(1'b0);
		u_host.wr(ADDR_EVT_SRC, 8'hFF);
		rchk(ADDR_EVT_SRC, 8'h00);
		rchk(8'h3F, 8'h00);
		// Threshold bytes and duration are independent storage
		u_host.wr(ADDR_THR_LO, 8'h5A);
		u_host.wr(ADDR_THR_HI, 8'hA5);
		u_host.wr(ADDR_DUR, 8'hC3);
		rchk(ADDR_THR_LO, 8'h5A);
		rchk(ADDR_THR_HI, 8'hA5);
		rchk(ADDR_DUR, 8'hC3);
		u_host.wr(ADDR_THR_LO, 8'h00);
		u_host.wr(ADDR_THR_HI, 8'h10);
		u_host.wr(ADDR_DUR, 8'h00);
		// Every byte order and alignment, negative Y exposes the sign fill
		for (int m = 0; m < 4; m++) begin
			u_host.wr(ADDR_CTRL2, fmt_mode[m]);
			smp(16'h0000, 16'h8A50, 16'h1234);
			rchk(ADDR_Y_LO, fmt_exp[m][31:24]);
			rchk(ADDR_Y_HI, fmt_exp[m][23:16]);
			rchk(ADDR_Z_LO, fmt_exp[m][15:8]);
			rchk(ADDR_Z_HI, fmt_exp[m][7:0]);
		end
		// Each enable alone; high side uses a negative value of large magnitude
		for (int i = 0; i < 6; i++) begin
			u_host.wr(ADDR_EVT_CFG, 8'h01 << i);
			v16 = i[0] ? 16'hD000 : 16'h0100;
			smp(v16, v16, v16);
			rchk(ADDR_EVT_SRC, 8'h40 | (8'h01 << i));
			ichk(1'b1);
		end
		// Equal to threshold is neither side; unlatched flags drop
		smp(16'h1000, 16'h1000, 16'h1000);
		rchk(ADDR_EVT_SRC, 8'h00);
		ichk(1'b0);
		// AND needs both enabled events, OR needs one
		u_host.wr(ADDR_EVT_CFG, 8'hA8);
		smp(16'h0000, 16'hD000, 16'hD000);
		rchk(ADDR_EVT_SRC, 8'h68);
		smp(16'h0000, 16'h0000, 16'hD000);
		rchk(ADDR_EVT_SRC, 8'h00);
		u_host.wr(ADDR_EVT_CFG, 8'h28);
		smp(16'h0000, 16'h0000, 16'hD000);
		rchk(ADDR_EVT_SRC, 8'h60);
		// Duration of three samples; a neutral sample breaks the old run first
		u_host.wr(ADDR_DUR, 8'h03);
		u_host.wr(ADDR_EVT_CFG, 8'h10);
		smp(16'h1000, 16'h1000, 16'h1000);
		for (int n = 1; n <= 3; n++) begin
			smp(16'h0000, 16'h0000, 16'h0000);
			rchk(ADDR_EVT_SRC, (n == 3) ? 8'h50 : 8'h00);
		end
		// Latched flags survive a quiet sample until acknowledged
		u_host.wr(ADDR_DUR, 8'h00);
		u_host.wr(ADDR_EVT_CFG, 8'h50);
		smp(16'h0000, 16'h0000, 16'h0000);
		smp(16'h0000, 16'h0000, 16'h1000);
		rchk(ADDR_EVT_SRC, 8'h50);
		ichk(1'b1);
		u_host.ack();
		rchk(ADDR_EVT_SRC, 8'h00);
		ichk(1'b0);
		// Steady large Z: no low event raw, low event once high-passed
		u_host.wr(ADDR_EVT_CFG, 8'h10);
		repeat (200) smp(16'h0000, 16'h0000, 16'h4000);
		rchk(ADDR_EVT_SRC, 8'h00);
		u_host.wr(ADDR_CTRL3, 8'h20);
		smp(16'h0000, 16'h0000, 16'h4000);
		rchk(ADDR_EVT_SRC, 8'h50);
		print_verdict();
	end
endmodule
